// *** ddl_host.sv ***
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Host end: AXI4-Lite controlled sequencer issuing bus I/O writes.
module ddl_host #(
  parameter int unsigned STROBE_CYC = ddl_pkg::IOW_CYC
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite slave.
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Expansion bus.
  ddl_bus_if.host          bus
);

  initial begin
    if (STROBE_CYC < 1 || STROBE_CYC > 7) begin
      $error("ddl_host STROBE_CYC must be 1 to 7.");
    end
  end

  logic        aw_reg, w_reg, bv_reg, rv_reg;
  logic [3:0]  awa_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [3:0]  ws_reg;
  logic [1:0]  br_reg, rr_reg;
  logic [7:0]  data_reg;
  logic [6:0]  base_reg;
  logic [2:0]  ofs_reg, cnt_reg;
  logic        done_reg, iow_n_reg;
  ddl_pkg::ddl_hw_e st_reg;

  // Write path decode once both address and data are held.
  wire logic do_wr   = aw_reg & w_reg & ~bv_reg;
  wire logic busy    = (st_reg != ddl_pkg::HW_IDLE);
  wire logic wr_data = do_wr & (awa_reg == ddl_pkg::HREG_DATA) & ws_reg[0];
  wire logic wr_base = do_wr & (awa_reg == ddl_pkg::HREG_BASE) & ws_reg[0];
  wire logic wr_ctrl = do_wr & (awa_reg == ddl_pkg::HREG_CTRL) & ws_reg[0];
  wire logic go      = wr_ctrl & wd_reg[ddl_pkg::CTRL_GO_BIT] & ~busy;
  wire logic map_w   = (awa_reg == ddl_pkg::HREG_CTRL) | (awa_reg == ddl_pkg::HREG_DATA)
                     | (awa_reg == ddl_pkg::HREG_BASE);
  wire logic map_r   = (s_axi_araddr[1:0] == 2'h0) & (s_axi_araddr != 4'h0 ? 1'b1 : 1'b1);
  wire logic [31:0] rmux =
      (s_axi_araddr == ddl_pkg::HREG_CTRL)   ? {28'h000_0000, ofs_reg, 1'b0} :
      (s_axi_araddr == ddl_pkg::HREG_DATA)   ? {24'h00_0000, data_reg} :
      (s_axi_araddr == ddl_pkg::HREG_STATUS) ? {30'h0000_0000, done_reg, busy} :
                                               {25'h000_0000, base_reg};

  // AXI channel handshakes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_reg <= 1'b0;
      w_reg  <= 1'b0;
      bv_reg <= 1'b0;
      rv_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      rd_reg <= 32'h0000_0000;
      br_reg <= ddl_pkg::RESP_OKAY;
      rr_reg <= ddl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_reg) begin
        aw_reg  <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_reg) begin
        w_reg  <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        bv_reg <= 1'b1;
        br_reg <= map_w ? ddl_pkg::RESP_OKAY : ddl_pkg::RESP_SLVERR;
      end else if (bv_reg & s_axi_bready) begin
        bv_reg <= 1'b0;
        aw_reg <= 1'b0;
        w_reg  <= 1'b0;
      end
      if (s_axi_arvalid & ~rv_reg) begin
        rv_reg <= 1'b1;
        rd_reg <= rmux;
        rr_reg <= map_r ? ddl_pkg::RESP_OKAY : ddl_pkg::RESP_SLVERR;
      end else if (rv_reg & s_axi_rready) begin
        rv_reg <= 1'b0;
      end
    end
  end

  // Controller registers and the bus write sequencer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_reg  <= 8'h00;
      base_reg  <= 7'h00;
      ofs_reg   <= 3'h0;
      done_reg  <= 1'b0;
      iow_n_reg <= 1'b1;
      cnt_reg   <= 3'h0;
      st_reg    <= ddl_pkg::HW_IDLE;
    end else begin
      if (wr_data & ~busy) begin
        data_reg <= wd_reg[7:0];
      end
      if (wr_base & ~busy) begin
        base_reg <= wd_reg[6:0];  // Host must choose a legal base. [R11]
      end
      case (st_reg)
        ddl_pkg::HW_IDLE: begin
          if (go) begin
            ofs_reg  <= wd_reg[ddl_pkg::CTRL_OFS_LSB +: 3];  // Software orders +4..+7. [R09]
            done_reg <= 1'b0;
            st_reg   <= ddl_pkg::HW_SETUP;
          end else if (wr_ctrl) begin
            done_reg <= 1'b0;
          end
        end
        ddl_pkg::HW_SETUP: begin
          iow_n_reg <= 1'b0;
          cnt_reg   <= 3'(STROBE_CYC);
          st_reg    <= ddl_pkg::HW_STROBE;
        end
        ddl_pkg::HW_STROBE: begin
          if (cnt_reg == 3'h1) begin
            iow_n_reg <= 1'b1;
            st_reg    <= ddl_pkg::HW_DONE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ddl_pkg::HW_DONE: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            st_reg <= ddl_pkg::HW_IDLE;
          end
          done_reg <= 1'b1;
        end
        default: begin
          st_reg <= ddl_pkg::HW_IDLE;
        end
      endcase
    end
  end

  // Outputs.
  assign s_axi_awready = ~aw_reg;
  assign s_axi_wready  = ~w_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = ~rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign bus.addr      = {base_reg, ofs_reg};
  assign bus.data_out  = data_reg;
  assign bus.data_oe_n = 1'b0;
  assign bus.iow_n     = iow_n_reg;
  assign bus.ior_n     = 1'b1;
  assign bus.aen       = 1'b0;

endmodule // ddl_host

// *** ddl_pkg.sv ***
// Shared constants and types for the dual converter loader and its host end.
package ddl_pkg;

  // Block geometry and code width.
  localparam int unsigned BLOCK_BYTES   = 8;
  localparam int unsigned CODE_W        = 12;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned SEL_W         = 7;

  // Offsets inside the block.
  localparam logic [2:0] OFS_CH0_LOW    = 3'h0;
  localparam logic [2:0] OFS_CH0_HIGH   = 3'h1;
  localparam logic [2:0] OFS_CH1_LOW    = 3'h2;
  localparam logic [2:0] OFS_CH1_HIGH   = 3'h3;
  localparam logic [2:0] OFS_SYNC_CH0_LOW  = 3'h4;
  localparam logic [2:0] OFS_SYNC_CH0_HIGH = 3'h5;
  localparam logic [2:0] OFS_SYNC_CH1_LOW  = 3'h6;
  localparam logic [2:0] OFS_SYNC_CH1_HIGH_BOTH = 3'h7;

  // Field positions of the low byte.
  localparam int unsigned LOW_NIB_MSB   = 7;
  localparam int unsigned LOW_NIB_LSB   = 4;

  // Value after reset of codes.
  localparam logic [11:0] CODE_RESET    = 12'h000;

  // Host controller register byte addresses on AXI4-Lite.
  localparam logic [3:0] HREG_CTRL      = 4'h0;
  localparam logic [3:0] HREG_DATA      = 4'h4;
  localparam logic [3:0] HREG_STATUS    = 4'h8;
  localparam logic [3:0] HREG_BASE      = 4'hC;

  // Control register fields: bit 0 start, bits 3:1 offset.
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_OFS_LSB  = 1;

  // Host bus cycle length in mclk periods (100 ns each).
  localparam int unsigned IOW_NS        = 300;
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned IOW_CYC       = (IOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  IOW_CYC_3     = 3'(IOW_CYC);

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Host write sequencer states.
  typedef enum logic [1:0] {HW_IDLE, HW_SETUP, HW_STROBE, HW_DONE} ddl_hw_e;

endpackage

// *** ddl_bus_if.sv ***
`timescale 1ns/1ps
// Host expansion-bus signals joining the host end and the card end.
interface ddl_bus_if;
  logic [9:0] addr;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic       iow_n;
  logic       ior_n;
  logic       aen;
  logic [7:0] card_data_out;
  logic       card_data_oe_n;

  modport host (
    output addr, data_out, data_oe_n, iow_n, ior_n, aen,
    input  card_data_out, card_data_oe_n
  );
  modport card (
    input  addr, data_out, data_oe_n, iow_n, ior_n, aen,
    output card_data_out, card_data_oe_n
  );
endinterface

// *** ddl_card.sv ***
`timescale 1ns/1ps
// Card end: address decode, double-buffered loading of two 12-bit converters.
//
// Contract
// R01: Card answers eight consecutive bytes at base.
// R02: Two independent channels, 12-bit code each.
// R03: Input buffer, then latch in one step.
// R04: Each channel has its own addresses.
// R05: Code loads as low nibble, high byte.
// R06: Codes are left-justified in sixteen bits.
// R07: Power-on clears both converter inputs.
// R08: Independent high-byte write updates its channel.
// R09: Host fills +4,+5,+6 before +7.
// R10: +4..+6 buffer only; +7 updates both.
// R11: Host picks legal, non-overlapping base address.
// R12: Decoder compares A3..A9 with switch bank.
// R13: Switch OFF matches 1, ON matches 0.
// R14: Bipolar codes complementary; zero is positive full.
// R15: +0/+1 channel 0, +2/+3 channel 1.
// R16: Low byte D7..D4 carries bits 3..0.
// R17: Capture only on matching write; never drive reads.
// R18: Low-byte write never disturbs latched output.
module ddl_card #(
  parameter int unsigned CODE_BITS = 12
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Host bus.
  ddl_bus_if.card          bus,
  // Base-address switches, one per line A3..A9, 1 means OFF.
  input  wire logic [6:0]  base_address_switch_bank,
  // Converter latch outputs and update strobes.
  output logic [11:0]      dac0_code,
  output logic [11:0]      dac1_code,
  output logic             dac0_update,
  output logic             dac1_update
);

  // Elaboration check: the latches and the byte split are fixed at twelve bits.
  // Other widths would need a different split of the code over the two bytes.
  if (CODE_BITS != ddl_pkg::CODE_W) begin : g_bad_code_bits
    $error("ddl_card supports only 12-bit codes.");
  end

  // Joins a high byte and a low nibble into one 12-bit code.
  // The high byte lands in bits 11..4, so the code stays left-justified.
  function automatic logic [11:0] join_code(input logic [7:0] hi, input logic [3:0] lo);
    return {hi, lo};  // [R06] [R16]
  endfunction

  // Address and data synchroniser stages.
  logic [9:0]  addr_s1_reg, addr_s2_reg;
  logic [7:0]  data_s1_reg, data_s2_reg;
  // Strobe and cycle-type stages; the third strobe stage feeds only the edge detector.
  logic        iow_s1_reg, iow_s2_reg, iow_s3_reg;
  logic        aen_s1_reg, aen_s2_reg;
  // Base-address switch stages.
  logic [6:0]  sw_s1_reg, sw_s2_reg;

  // Channel input buffers.
  logic [3:0]  buf0_low_reg, buf1_low_reg;
  logic [7:0]  buf0_high_reg;
  // Converter latches and their update pulses.
  logic [11:0] lat0_reg, lat1_reg;
  logic        upd0_reg, upd1_reg;

  // Address and data synchronisers; the host holds both steady around the strobe.
  // Every pin passes two flip-flops before any decode reads it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_s1_reg <= 10'h000;
      addr_s2_reg <= 10'h000;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
    end else begin
      addr_s1_reg <= bus.addr;
      addr_s2_reg <= addr_s1_reg;
      data_s1_reg <= bus.data_out;
      data_s2_reg <= data_s1_reg;
    end
  end

  // Strobe synchronisers reset to the idle level, so no false edge follows reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      iow_s1_reg <= 1'b1;
      iow_s2_reg <= 1'b1;
      iow_s3_reg <= 1'b1;
      aen_s1_reg <= 1'b1;
      aen_s2_reg <= 1'b1;
    end else begin
      iow_s1_reg <= bus.iow_n;
      iow_s2_reg <= iow_s1_reg;
      iow_s3_reg <= iow_s2_reg;
      aen_s1_reg <= bus.aen;
      aen_s2_reg <= aen_s1_reg;
    end
  end

  // Switch synchronisers; the bank may be moved while the card is powered.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw_s1_reg <= 7'h00;
      sw_s2_reg <= 7'h00;
    end else begin
      sw_s1_reg <= base_address_switch_bank;
      sw_s2_reg <= sw_s1_reg;
    end
  end

  // Strobe edge and block match: a write counts when its strobe ends.
  // Cycles with the address-enable line high belong to DMA and are never taken.
  wire logic       iow_rise  = iow_s2_reg & ~iow_s3_reg;
  wire logic       blk_hit   = (addr_s2_reg[9:3] == sw_s2_reg);  // [R12] [R13] [R01]
  wire logic       wr_hit    = iow_rise & blk_hit & ~aen_s2_reg; // [R17]

  // Address bits 2..0 pick the location inside the eight-byte block.
  wire logic [2:0] ofs       = addr_s2_reg[2:0];
  wire logic [3:0] low_nib   = data_s2_reg[ddl_pkg::LOW_NIB_MSB:ddl_pkg::LOW_NIB_LSB]; // [R16]

  // Offset decode: each channel's low nibble buffer serves both offset groups.
  wire logic       wr_low0   = wr_hit & ((ofs == ddl_pkg::OFS_CH0_LOW)
                                       | (ofs == ddl_pkg::OFS_SYNC_CH0_LOW));   // [R15] [R04]
  wire logic       wr_high0  = wr_hit & (ofs == ddl_pkg::OFS_CH0_HIGH);          // [R08]
  wire logic       wr_bhigh0 = wr_hit & (ofs == ddl_pkg::OFS_SYNC_CH0_HIGH);     // [R10]
  wire logic       wr_low1   = wr_hit & ((ofs == ddl_pkg::OFS_CH1_LOW)
                                       | (ofs == ddl_pkg::OFS_SYNC_CH1_LOW));   // [R04]
  wire logic       wr_high1  = wr_hit & (ofs == ddl_pkg::OFS_CH1_HIGH);          // [R15]
  wire logic       wr_both   = wr_hit & (ofs == ddl_pkg::OFS_SYNC_CH1_HIGH_BOTH); // [R10]

  // Update requests; a joint update pulses both channels in the same cycle.
  wire logic       upd0_next = wr_high0 | wr_both;
  wire logic       upd1_next = wr_high1 | wr_both;

  // Candidate codes for the latches, from the buffers and the bus byte.
  wire logic [11:0] code0_direct = join_code(data_s2_reg, buf0_low_reg);   // [R08] [R02]
  wire logic [11:0] code0_joint  = join_code(buf0_high_reg, buf0_low_reg); // [R10] [R03]
  wire logic [11:0] code1_next   = join_code(data_s2_reg, buf1_low_reg);   // [R08] [R10]

  // Channel 0 input buffer; offsets +0 and +4 share the low nibble.
  // Nothing here touches a latch, so a low-byte write leaves the output alone.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf0_low_reg  <= 4'h0;  // [R07]
      buf0_high_reg <= 8'h00;
    end else begin
      if (wr_low0) begin
        buf0_low_reg <= low_nib;  // [R05] [R18]
      end
      if (wr_bhigh0) begin
        buf0_high_reg <= data_s2_reg;  // [R03]
      end
    end
  end

  // Channel 1 input buffer; only the low nibble waits here.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf1_low_reg <= 4'h0;  // [R07]
    end else if (wr_low1) begin
      buf1_low_reg <= low_nib;  // [R05]
    end
  end

  // Channel 0 latch moves on its own high byte or on the joint update.
  // The two offsets never hit in one cycle; the order only fixes priority.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lat0_reg <= ddl_pkg::CODE_RESET;  // [R07]
    end else if (wr_high0) begin
      lat0_reg <= code0_direct;
    end else if (wr_both) begin
      lat0_reg <= code0_joint;
    end
  end

  // Channel 1 latch moves on its own high byte or on the joint update.
  // Both paths take the fresh bus byte as bits 11..4.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lat1_reg <= ddl_pkg::CODE_RESET;  // [R07]
    end else if (upd1_next) begin
      lat1_reg <= code1_next;
    end
  end

  // Update pulses mark the cycle in which each latch takes a new code.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upd0_reg <= 1'b0;
      upd1_reg <= 1'b0;
    end else begin
      upd0_reg <= upd0_next;
      upd1_reg <= upd1_next;
    end
  end

  // Codes pass as written; bipolar complement is the analog stage's job.
  // A bipolar stage therefore reads code 0 as positive full scale.
  assign dac0_code   = lat0_reg;  // [R14]
  assign dac1_code   = lat1_reg;
  assign dac0_update = upd0_reg;
  assign dac1_update = upd1_reg;

  // The card is write-only and never drives the data bus.
  // Read strobes are ignored, so a read of the block finds the bus undriven by the card.
  assign bus.card_data_out  = 8'h00;  // [R17]
  assign bus.card_data_oe_n = 1'b1;

endmodule // ddl_card

// *** ddl_bus_asserts.sv ***
// Concurrent checks on the expansion bus and the converter latches.
`timescale 1ns/1ps
module ddl_bus_asserts (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst,
  // Bus as seen by the card.
  input wire logic [9:0]  addr,
  input wire logic        iow_n,
  input wire logic        aen,
  input wire logic        card_data_oe_n,
  input wire logic [6:0]  base_address_switch_bank,
  // Converter side.
  input wire logic [11:0] dac0_code,
  input wire logic [11:0] dac1_code,
  input wire logic        dac0_update,
  input wire logic        dac1_update
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // A finished write strobe whose upper address matches the switch bank.
  sequence match_s;
    $rose(iow_n) && !aen && (addr[9:3] == base_address_switch_bank);
  endsequence
  // A finished write strobe aimed at some other block.
  sequence foreign_s;
    $rose(iow_n) && !aen && (addr[9:3] != base_address_switch_bank);
  endsequence
  // No latch moves for six cycles.
  sequence quiet_s;
    ##1 (!dac0_update && !dac1_update) [*6];
  endsequence

  // The card never drives the data bus.
  never_drive_a: assert property (card_data_oe_n)
    else $error("card drove the data bus");
  reset_clear_a: assert property ($fell(rst) |-> dac0_code == 12'h000 && dac1_code == 12'h000)
    else $error("codes not cleared by reset");
  latch0_step_a: assert property ($changed(dac0_code) |-> dac0_update)
    else $error("channel 0 latch moved without update");
  latch1_step_a: assert property ($changed(dac1_code) |-> dac1_update)
    else $error("channel 1 latch moved without update");
  ch0_update_a: assert property ((match_s ##0 (addr[2:0] == 3'h1)) |-> ##[2:6] dac0_update)
    else $error("channel 0 high byte gave no update");
  ch1_update_a: assert property ((match_s ##0 (addr[2:0] == 3'h3)) |-> ##[2:6] dac1_update)
    else $error("channel 1 high byte gave no update");
  both_update_a: assert property ((match_s ##0 (addr[2:0] == 3'h7))
    |-> ##[2:6] (dac0_update && dac1_update))
    else $error("joint update not simultaneous");
  buffer_only_a: assert property ((match_s ##0 (addr[2] && addr[1:0] != 2'h3)) |-> quiet_s)
    else $error("buffer write moved a latch");
  low_quiet_a: assert property ((match_s ##0 (!addr[2] && !addr[0])) |-> quiet_s)
    else $error("low byte write moved a latch");
  foreign_quiet_a: assert property (foreign_s |-> quiet_s)
    else $error("write to another block was taken");
endmodule // ddl_bus_asserts

// *** test_dual_dac_double_buffer_loader.sv ***
// Self-checking bench: AXI4-Lite orders into the host end, card end loads.
`timescale 1ns/1ps
module test_dual_dac_double_buffer_loader;
  // Clock, reset, switches and counters.
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic [6:0]  sw   = 7'h60;
  logic [31:0] s;
  int          err_count = 0;
  int          cmp_count = 0;
  // AXI4-Lite master side.
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  // Converter outputs.
  logic [11:0] dac0_code, dac1_code;
  logic        dac0_update, dac1_update;

  // Clock at 10 MHz.
  always #50 mclk = ~mclk;

  ddl_bus_if ddl_bus_if_inst ();

  ddl_host ddl_host_inst (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(ddl_bus_if_inst));

  ddl_card ddl_card_inst (.mclk(mclk), .rst(rst), .bus(ddl_bus_if_inst),
    .base_address_switch_bank(sw), .dac0_code(dac0_code), .dac1_code(dac1_code),
    .dac0_update(dac0_update), .dac1_update(dac1_update));

  ddl_bus_asserts ddl_bus_asserts_inst (.mclk(mclk), .rst(rst),
    .addr(ddl_bus_if_inst.addr), .iow_n(ddl_bus_if_inst.iow_n), .aen(ddl_bus_if_inst.aen),
    .card_data_oe_n(ddl_bus_if_inst.card_data_oe_n), .base_address_switch_bank(sw),
    .dac0_code(dac0_code), .dac1_code(dac1_code),
    .dac0_update(dac0_update), .dac1_update(dac1_update));

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A wait that ran out of bound counts as a mismatch.
  task automatic give_up();
    err_count++;
    $display("wait bound ran out at %0t", $time);
    print_verdict();
  endtask

  // Compares one value with its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Compares both converter latches.
  task automatic chk_dac(input logic [11:0] e0, input logic [11:0] e1);
    chk({20'h0_0000, dac0_code}, {20'h0_0000, e0});
    chk({20'h0_0000, dac1_code}, {20'h0_0000, e1});
  endtask

  // AXI4-Lite write: address and data offered together, each released when taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) give_up();
    chk({30'h0000_0000, bresp}, {30'h0000_0000, ddl_pkg::RESP_OKAY});
  endtask

  // AXI4-Lite read.
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    if (n == 100) give_up();
  endtask

  // One bus write at an offset; then three card edges plus margin for the latch.
  task automatic io_wr(input logic [2:0] o, input logic [7:0] b);
    logic [31:0] st;
    int          n;
    axw(ddl_pkg::HREG_DATA, {24'h00_0000, b});
    axw(ddl_pkg::HREG_CTRL, {28'h000_0000, o, 1'b1});
    for (n = 0; n < 50; n++) begin
      axr(ddl_pkg::HREG_STATUS, st);
      if (st[1]) break;
    end
    if (n == 50) give_up();
    repeat (8) @(posedge mclk);
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk_dac(12'h000, 12'h000);
    axw(ddl_pkg::HREG_BASE, 32'h0000_0060);
    axr(ddl_pkg::HREG_BASE, s);
    chk(s, 32'h0000_0060);
    $display("test reset done");
    io_wr(3'h0, 8'hA5);
    chk_dac(12'h000, 12'h000);
    io_wr(3'h1, 8'h3C);
    chk_dac(12'h3CA, 12'h000);
    $display("test channel 0 done");
    io_wr(3'h2, 8'h7F);
    io_wr(3'h3, 8'hFF);
    chk_dac(12'h3CA, 12'hFF7);
    $display("test channel 1 done");
    io_wr(3'h4, 8'h19);
    io_wr(3'h5, 8'h12);
    io_wr(3'h6, 8'h2E);
    chk_dac(12'h3CA, 12'hFF7);
    io_wr(3'h7, 8'h34);
    chk_dac(12'h121, 12'h342);
    $display("test joint update done");
    axw(ddl_pkg::HREG_BASE, 32'h0000_0061);
    io_wr(3'h1, 8'hFF);
    chk_dac(12'h121, 12'h342);
    axw(ddl_pkg::HREG_BASE, 32'h0000_0060);
    io_wr(3'h1, 8'h00);
    chk_dac(12'h001, 12'h342);
    $display("test base decode done");
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk_dac(12'h000, 12'h000);
    axw(ddl_pkg::HREG_BASE, 32'h0000_0060);
    io_wr(3'h1, 8'h5A);
    chk_dac(12'h5A0, 12'h000);
    $display("test second reset done");
    print_verdict();
  end
endmodule // test_dual_dac_double_buffer_loader
